// >>> core/lcdpt_core.sv
// Panel timing generator with frame fetch engine and register port.
`timescale 1ns/1ps
`include "lcdpt_defs.svh"
module lcdpt_core
  import lcdpt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // System bus fetch
  output logic busReq,
  output logic [7:0] busBurstLen,
  input wire logic busWordValid,
  input wire logic [31:0] busWordData,
  // Panel pins
  output logic pixelClockPin,
  output logic verticalSyncPin,
  output logic horizontalSyncPin,
  output logic dataEnablePin,
  output logic [23:0] panelDataPins
);
  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  logic [31:0] dmaCfg, dmaCtrl, ctrl1, ctrl2, vTim, hTim, sizeCfg;
  logic [31:0] next_dmaCfg, next_dmaCtrl, next_ctrl1, next_ctrl2;
  logic [31:0] next_vTim, next_hTim, next_sizeCfg, next_regRdData;
  logic [22:0] frameWordCount;
  logic [6:0] burstLenMinusOne;
  logic fetchEnable, softReset, bypass, singlePanel;
  logic [8:0] pixelClockDivisor;
  logic [1:0] panelType, dataBusWidth, byteOrdering;
  logic [2:0] bitsPerPixel;
  logic [10:0] currentLine, lineCountMinusOne, rowWidthValue, hFrontIdle;
  logic [7:0] vFrontIdle, vBackIdle, hBackIdle;
  logic [5:0] vPulseLen, hPulseLen;
  logic [3:0] vsyncToHsyncDelay;
  logic fetchActive;

  assign frameWordCount = dmaCfg[`LCDPT_FRM_LSB +: 23];
  assign burstLenMinusOne = dmaCfg[`LCDPT_BRST_LSB +: 7];
  assign fetchEnable = dmaCtrl[`LCDPT_EN_BIT];
  assign softReset = regWr && regAddr == `LCDPT_OFS_DMA_CTRL && regWrData[`LCDPT_SRST_BIT];
  assign bypass = ctrl1[`LCDPT_BYP_BIT];
  assign pixelClockDivisor = ctrl1[`LCDPT_DIV_LSB +: 9];
  assign panelType = ctrl2[`LCDPT_TYPE_LSB +: 2];
  assign singlePanel = !ctrl2[`LCDPT_SCAN_BIT];
  assign dataBusWidth = ctrl2[`LCDPT_IFW_LSB +: 2];
  assign bitsPerPixel = ctrl2[`LCDPT_BPP_LSB +: 3];
  assign byteOrdering = ctrl2[`LCDPT_ORD_LSB +: 2];
  assign vFrontIdle = vTim[`LCDPT_VFRONT_LSB +: 8];
  assign vBackIdle = vTim[`LCDPT_VBACK_LSB +: 8];
  assign vPulseLen = vTim[`LCDPT_VPULSE_LSB +: 6];
  assign vsyncToHsyncDelay = vTim[`LCDPT_VHD_LSB +: 4];
  assign hBackIdle = hTim[`LCDPT_HBACK_LSB +: 8];
  assign hPulseLen = hTim[`LCDPT_HPULSE_LSB +: 6];
  assign hFrontIdle = hTim[`LCDPT_HFRONT_LSB +: 11];
  assign lineCountMinusOne = sizeCfg[`LCDPT_LVAL_LSB +: 11];
  assign rowWidthValue = sizeCfg[`LCDPT_HOZ_LSB +: 11];

  always_comb begin
    next_dmaCfg = dmaCfg;
    next_dmaCtrl = dmaCtrl;
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_vTim = vTim;
    next_hTim = hTim;
    next_sizeCfg = sizeCfg;
    if (regWr) begin
      case (regAddr)
        `LCDPT_OFS_DMA_CFG: next_dmaCfg = regWrData & 32'h7F7FFFFF;
        `LCDPT_OFS_DMA_CTRL: next_dmaCtrl = {31'h0, regWrData[`LCDPT_EN_BIT]};
        `LCDPT_OFS_CTRL1: next_ctrl1 = regWrData & 32'h001FF001;
        `LCDPT_OFS_CTRL2: next_ctrl2 = regWrData & 32'hC0009FFF;
        `LCDPT_OFS_VTIM: next_vTim = regWrData & 32'h0F3FFFFF;
        `LCDPT_OFS_HTIM: next_hTim = regWrData & 32'hFFE03FFF;
        `LCDPT_OFS_SIZE: next_sizeCfg = regWrData & 32'hFFE007FF;
        default: next_dmaCfg = dmaCfg;
      endcase
    end
    next_regRdData = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        `LCDPT_OFS_DMA_CFG: next_regRdData = dmaCfg;
        `LCDPT_OFS_DMA_CTRL: next_regRdData = {29'h0, fetchActive, 1'b0, fetchEnable};
        `LCDPT_OFS_CTRL1: next_regRdData = {currentLine, ctrl1[20:0]};
        `LCDPT_OFS_CTRL2: next_regRdData = ctrl2;
        `LCDPT_OFS_VTIM: next_regRdData = vTim;
        `LCDPT_OFS_HTIM: next_regRdData = hTim;
        `LCDPT_OFS_SIZE: next_regRdData = sizeCfg;
        default: next_regRdData = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dmaCfg <= `LCDPT_RST_DMA_CFG;
      dmaCtrl <= `LCDPT_RST_DMA_CTRL;
      ctrl1 <= `LCDPT_RST_CTRL1;
      ctrl2 <= `LCDPT_RST_CTRL2;
      vTim <= `LCDPT_RST_VTIM;
      hTim <= `LCDPT_RST_HTIM;
      sizeCfg <= `LCDPT_RST_SIZE;
      regRdData <= 32'h00000000;
    end else begin
      dmaCfg <= next_dmaCfg;
      dmaCtrl <= next_dmaCtrl;
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      vTim <= next_vTim;
      hTim <= next_hTim;
      sizeCfg <= next_sizeCfg;
      regRdData <= next_regRdData;
    end
  end

  //----------------------------------------------------------------------------
  // Pixel clock divider
  //----------------------------------------------------------------------------
  logic [8:0] divCnt, next_divCnt;
  logic clkPhase, next_clkPhase, pixEn;

  // The phase steps with the pixel state; the pin copy lags one cycle to match the data pins.
  always_comb begin
    next_divCnt = divCnt;
    next_clkPhase = clkPhase;
    pixEn = 1'b0;
    if (bypass) begin
      next_divCnt = 9'h000;
      next_clkPhase = 1'b0;
      pixEn = fetchEnable;
    end else if (divCnt == pixelClockDivisor) begin
      next_divCnt = 9'h000;
      next_clkPhase = !clkPhase;
      pixEn = fetchEnable && !clkPhase;
    end else begin
      next_divCnt = divCnt + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divCnt <= 9'h000;
      clkPhase <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      clkPhase <= next_clkPhase;
    end
  end

  //----------------------------------------------------------------------------
  // Horizontal and vertical timing
  //----------------------------------------------------------------------------
  lcdpt_hstate_t hState, next_hState;
  lcdpt_vstate_t vState, next_vState;
  logic [10:0] hCnt, next_hCnt, vCnt, next_vCnt, next_currentLine, vStepPoint;
  logic vertStep, lineEnd, frameStart;

  assign lineEnd = pixEn && hState == LCDPT_H_FRONT && hCnt == 11'h000;
  // Vertical state moves ahead of the line start so that hsync trails the vsync edge.
  assign vStepPoint = ({7'h0, vsyncToHsyncDelay} + 11'h001 > hFrontIdle) ? hFrontIdle :
                      {7'h0, vsyncToHsyncDelay} + 11'h001;
  assign vertStep = pixEn && hState == LCDPT_H_FRONT && hCnt == vStepPoint;
  assign frameStart = vertStep && next_vState == LCDPT_V_PULSE && vState != LCDPT_V_PULSE;

  always_comb begin
    next_hState = hState;
    next_hCnt = hCnt;
    if (pixEn) begin
      if (hCnt != 11'h000) begin
        next_hCnt = hCnt - 11'h001;
      end else begin
        case (hState)
          LCDPT_H_PULSE: begin
            next_hState = LCDPT_H_BACK;
            next_hCnt = {3'h0, hBackIdle};
          end
          LCDPT_H_BACK: begin
            next_hState = LCDPT_H_DATA;
            next_hCnt = rowWidthValue;
          end
          LCDPT_H_DATA: begin
            next_hState = LCDPT_H_FRONT;
            next_hCnt = hFrontIdle;
          end
          default: begin
            next_hState = LCDPT_H_PULSE;
            next_hCnt = {5'h00, hPulseLen};
          end
        endcase
      end
    end
    if (!fetchEnable || softReset) begin
      next_hState = LCDPT_H_FRONT;
      next_hCnt = hFrontIdle;
    end
  end

  always_comb begin
    next_vState = vState;
    next_vCnt = vCnt;
    next_currentLine = currentLine;
    if (vertStep) begin
      if (vCnt != 11'h000) begin
        next_vCnt = vCnt - 11'h001;
        if (vState == LCDPT_V_DATA) begin
          next_currentLine = currentLine - 11'h001;
        end
      end else begin
        case (vState)
          LCDPT_V_PULSE: begin
            next_vState = (vBackIdle == 8'h00) ? LCDPT_V_DATA : LCDPT_V_BACK;
            next_vCnt = (vBackIdle == 8'h00) ? lineCountMinusOne :
                        {3'h0, vBackIdle - 8'h01};
            next_currentLine = lineCountMinusOne;
          end
          LCDPT_V_BACK: begin
            next_vState = LCDPT_V_DATA;
            next_vCnt = lineCountMinusOne;
            next_currentLine = lineCountMinusOne;
          end
          LCDPT_V_DATA: begin
            next_vState = (vFrontIdle == 8'h00) ? LCDPT_V_PULSE : LCDPT_V_FRONT;
            next_vCnt = (vFrontIdle == 8'h00) ? {5'h00, vPulseLen} :
                        {3'h0, vFrontIdle - 8'h01};
          end
          default: begin
            next_vState = LCDPT_V_PULSE;
            next_vCnt = {5'h00, vPulseLen};
          end
        endcase
      end
    end
    if (!fetchEnable || softReset) begin
      next_vState = LCDPT_V_FRONT;
      next_vCnt = 11'h000;
      next_currentLine = 11'h000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hState <= LCDPT_H_FRONT;
      hCnt <= 11'h000;
      vState <= LCDPT_V_FRONT;
      vCnt <= 11'h000;
      currentLine <= 11'h000;
    end else begin
      hState <= next_hState;
      hCnt <= next_hCnt;
      vState <= next_vState;
      vCnt <= next_vCnt;
      currentLine <= next_currentLine;
    end
  end

  //----------------------------------------------------------------------------
  // Frame fetch engine
  //----------------------------------------------------------------------------
  lcdpt_dstate_t dState, next_dState;
  logic [22:0] wordsLeft, next_wordsLeft;
  logic [7:0] beatsLeft, next_beatsLeft, burstLen;
  logic secondPanel, next_secondPanel;

  assign burstLen = {1'b0, burstLenMinusOne} + 8'h01;
  assign fetchActive = dState == LCDPT_D_BURST;
  assign busReq = fetchActive;
  assign busBurstLen = beatsLeft;

  always_comb begin
    next_dState = dState;
    next_wordsLeft = wordsLeft;
    next_beatsLeft = beatsLeft;
    next_secondPanel = secondPanel;
    case (dState)
      LCDPT_D_IDLE: begin
        if (fetchEnable && !frameStart && wordsLeft != 23'h000000) begin
          next_dState = LCDPT_D_BURST;
          next_beatsLeft = (wordsLeft < {15'h0000, burstLen}) ? wordsLeft[7:0] : burstLen;
        end else if (fetchEnable && wordsLeft == 23'h000000 && secondPanel) begin
          next_wordsLeft = frameWordCount;
          next_secondPanel = 1'b0;
        end
      end
      LCDPT_D_BURST: begin
        if (busWordValid) begin
          next_beatsLeft = beatsLeft - 8'h01;
          next_wordsLeft = wordsLeft - 23'h000001;
          if (beatsLeft == 8'h01) begin
            next_dState = LCDPT_D_IDLE;
          end
        end
      end
      default: next_dState = LCDPT_D_IDLE;
    endcase
    // A new frame reloads the count even in mid-burst, so a slow fetch never runs over.
    if (frameStart) begin
      next_wordsLeft = frameWordCount;
      next_secondPanel = !singlePanel;
    end
    if (softReset) begin
      next_dState = LCDPT_D_IDLE;
      next_wordsLeft = 23'h000000;
      next_beatsLeft = 8'h00;
      next_secondPanel = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dState <= LCDPT_D_IDLE;
      wordsLeft <= 23'h000000;
      beatsLeft <= 8'h00;
      secondPanel <= 1'b0;
    end else begin
      dState <= next_dState;
      wordsLeft <= next_wordsLeft;
      beatsLeft <= next_beatsLeft;
      secondPanel <= next_secondPanel;
    end
  end

  //----------------------------------------------------------------------------
  // Pixel unpacking and pin drive
  //----------------------------------------------------------------------------
  logic [31:0] pixWord, next_pixWord;
  logic [23:0] pixData, next_panelData, lineMask;
  logic [5:0] pixBits;
  logic activeArea, next_vsync, next_hsync, next_dataEn, fourLines, clkGate;
  logic clkLevel, clkOn;

  assign activeArea = hState == LCDPT_H_DATA && vState == LCDPT_V_DATA;
  assign fourLines = dataBusWidth == 2'h0 || (dataBusWidth == 2'h1 && !singlePanel);
  // Passive panels only drive the valid data lines; the bus width code and the scan mode decide how many.
  assign lineMask = (panelType == LCDPT_ACTIVE) ? 24'hFFFFFF :
                    (fourLines ? 24'h00000F : 24'h0000FF);
  assign clkGate = ctrl2[`LCDPT_FREE_BIT] || activeArea;

  always_comb begin
    case (bitsPerPixel)
      3'h0: pixBits = 6'h01;
      3'h1: pixBits = 6'h02;
      3'h2: pixBits = 6'h04;
      3'h3: pixBits = 6'h08;
      3'h4: pixBits = 6'h10;
      3'h5: pixBits = (panelType == LCDPT_ACTIVE) ? 6'h18 : 6'h10;
      default: pixBits = 6'h10;
    endcase
    // Big endian takes each pixel from the top of the word, little endian from the bottom.
    if (byteOrdering == 2'h2) begin
      pixData = pixWord[23:0] & ((24'h000001 << pixBits) - 24'h000001);
    end else begin
      pixData = 24'(pixWord >> (6'd32 - pixBits)) & ((24'h000001 << pixBits) - 24'h000001);
    end
    next_pixWord = pixWord;
    if (busWordValid && fetchActive) begin
      next_pixWord = busWordData;
    end else if (pixEn && activeArea) begin
      next_pixWord = (byteOrdering == 2'h2) ? pixWord >> pixBits : pixWord << pixBits;
    end
    next_panelData = {24{ctrl2[`LCDPT_INVD_BIT]}} ^ ((activeArea ? pixData : 24'h000000) &
                     lineMask);
    next_vsync = (vState == LCDPT_V_PULSE) ^ ctrl2[`LCDPT_INVV_BIT];
    next_hsync = (hState == LCDPT_H_PULSE) ^ ctrl2[`LCDPT_INVH_BIT];
    next_dataEn = activeArea ^ ctrl2[`LCDPT_INVE_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pixWord <= 32'h00000000;
      panelDataPins <= 24'h000000;
      verticalSyncPin <= 1'b0;
      horizontalSyncPin <= 1'b0;
      dataEnablePin <= 1'b0;
      clkLevel <= 1'b0;
      clkOn <= 1'b0;
    end else begin
      pixWord <= next_pixWord;
      panelDataPins <= next_panelData;
      verticalSyncPin <= next_vsync;
      horizontalSyncPin <= next_hsync;
      dataEnablePin <= next_dataEn;
      clkLevel <= clkPhase;
      clkOn <= clkGate && fetchEnable;
    end
  end

  // Both clock sources rise with the registered data pins, so data is steady at the fall.
  assign pixelClockPin = ctrl2[`LCDPT_INVC_BIT] ^ (clkOn &&
                         (bypass ? ref_clk : clkLevel));

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  soft_reset_idle_a: assert property (softReset |=> !fetchActive && wordsLeft == 23'h0)
    else $error("fetch engine not idle after soft reset");
  busy_request_a: assert property (busReq |-> fetchActive && busBurstLen != 8'h00)
    else $error("bus request outside a burst");
  burst_length_a: assert property (dState == LCDPT_D_IDLE && next_dState == LCDPT_D_BURST
      && wordsLeft >= {15'h0000, burstLen} |=> busBurstLen == $past(burstLen))
    else $error("burst length not burst field plus one");
  frame_load_a: assert property (frameStart && !softReset |=>
      wordsLeft == $past(frameWordCount))
    else $error("frame word count not loaded at frame start");
  bypass_rate_a: assert property (bypass && fetchEnable |-> pixEn)
    else $error("bypass does not advance every clock");
  divider_rate_a: assert property (pixEn && !bypass && pixelClockDivisor == 9'h002
      && $stable(ctrl1) |=> !pixEn [*5] ##1 pixEn)
    else $error("pixel period not twice divisor plus one");
  line_count_a: assert property (vertStep && vState == LCDPT_V_DATA && vCnt != 11'h0
      && fetchEnable && !softReset |=> currentLine == $past(currentLine) - 11'h001)
    else $error("line counter did not count down");
  hsync_width_a: assert property (pixEn && hState == LCDPT_H_PULSE && hCnt == 11'h0
      && fetchEnable && !softReset |=> hState == LCDPT_H_BACK
      && hCnt == {3'h0, $past(hBackIdle)})
    else $error("back idle not loaded after hsync");
  hsync_load_a: assert property (lineEnd && !softReset && fetchEnable |=>
      hState == LCDPT_H_PULSE && hCnt == {5'h0, $past(hPulseLen)})
    else $error("hsync width not pulse field plus one");
  vsync_pin_a: assert property (##1 verticalSyncPin ==
      ($past(vState == LCDPT_V_PULSE) ^ $past(ctrl2[`LCDPT_INVV_BIT])))
    else $error("vsync pin does not follow pulse state");
  clock_gate_a: assert property (!bypass && !clkGate |=>
      pixelClockPin == ctrl2[`LCDPT_INVC_BIT])
    else $error("pixel clock toggles outside active area");
  data_mask_a: assert property (panelType != LCDPT_ACTIVE && fourLines && $stable(ctrl2)
      |=> (panelDataPins & 24'hFFFFF0) ==
      ({24{$past(ctrl2[`LCDPT_INVD_BIT])}} & 24'hFFFFF0))
    else $error("invalid passive data lines driven");

  frame_cover_c: cover property (frameStart);
  burst_done_c: cover property (fetchActive ##1 !fetchActive);
  line_end_c: cover property (lineEnd && vState == LCDPT_V_DATA);
endmodule // lcdpt_core

// >>> pkg/lcdpt_defs.svh
// Register map, field positions and reset values of the panel timing core.
//------------------------------------------------------------------------------
// How it works
//------------------------------------------------------------------------------
// How it works
// - Frame word count sets words fetched per frame, or per panel in dual scan.
// - Each burst moves burst_len_minus_one plus one words, or the words left in the frame if fewer.
// - Writing 1 to fetch_soft_reset resets the fetch engine; 0 does nothing.
// - fetch_active reads 1 while a bus burst runs, 0 when idle.
// - Bypass makes the pixel clock equal the controller clock.
// - Otherwise pixel clock is system clock over two times (divisor plus one).
// - current_line counts down from line_count_minus_one to zero each frame.
// - bits_per_pixel codes 0..5 give 1,2,4,8,16,24 bits, with code 5 giving 16 on passive panels; 6,7 reserved.
// - Invert bits flip clock edge, sync, data enable and data polarity.
// - Free run bit keeps the pixel clock running outside active display.
// - Active matrix adds vertical_front_idle idle lines at frame end.
// - Active matrix adds vertical_back_idle idle lines at frame start.
// - Vertical sync lasts vertical_pulse_len plus one lines.
// - Horizontal sync rises vsync_to_hsync_delay plus one pixels after a vsync edge; the code caps the delay at horizontal_front_idle pixels.
// - Each line starts with horizontal_back_idle plus one idle pixels.
// - Horizontal sync lasts horizontal_pulse_len plus one pixels.
// - Each line ends with horizontal_front_idle plus one idle pixels.
// - Four data lines valid in 4-bit single or dual and in 8-bit dual, else eight.
`ifndef LCDPT_DEFS_SVH
`define LCDPT_DEFS_SVH
`define LCDPT_ADDR_W 12
`define LCDPT_OFS_DMA_CFG 12'h018
`define LCDPT_OFS_DMA_CTRL 12'h01C
`define LCDPT_OFS_CTRL1 12'h800
`define LCDPT_OFS_CTRL2 12'h804
`define LCDPT_OFS_VTIM 12'h808
`define LCDPT_OFS_HTIM 12'h80C
`define LCDPT_OFS_SIZE 12'h810
`define LCDPT_RST_DMA_CFG 32'h00000000
`define LCDPT_RST_DMA_CTRL 32'h00000000
`define LCDPT_RST_CTRL1 32'h00002000
`define LCDPT_RST_CTRL2 32'h00000000
`define LCDPT_RST_VTIM 32'h00000000
`define LCDPT_RST_HTIM 32'h00000000
`define LCDPT_RST_SIZE 32'h00000000
`define LCDPT_FRM_LSB 0
`define LCDPT_BRST_LSB 24
`define LCDPT_EN_BIT 0
`define LCDPT_SRST_BIT 1
`define LCDPT_BUSY_BIT 2
`define LCDPT_BYP_BIT 0
`define LCDPT_DIV_LSB 12
`define LCDPT_LINE_LSB 21
`define LCDPT_TYPE_LSB 0
`define LCDPT_SCAN_BIT 2
`define LCDPT_IFW_LSB 3
`define LCDPT_BPP_LSB 5
`define LCDPT_INVD_BIT 8
`define LCDPT_INVV_BIT 9
`define LCDPT_INVH_BIT 10
`define LCDPT_INVC_BIT 11
`define LCDPT_INVE_BIT 12
`define LCDPT_FREE_BIT 15
`define LCDPT_ORD_LSB 30
`define LCDPT_VFRONT_LSB 0
`define LCDPT_VBACK_LSB 8
`define LCDPT_VPULSE_LSB 16
`define LCDPT_VHD_LSB 24
`define LCDPT_HBACK_LSB 0
`define LCDPT_HPULSE_LSB 8
`define LCDPT_HFRONT_LSB 21
`define LCDPT_LVAL_LSB 0
`define LCDPT_HOZ_LSB 21
`endif

// >>> pkg/lcdpt_pkg.sv
// Types shared by the panel timing core.
package lcdpt_pkg;
  typedef enum logic [1:0] {LCDPT_MONO = 2'h0, LCDPT_COLOR = 2'h1, LCDPT_ACTIVE = 2'h2}
    lcdpt_type_t;
  typedef enum {LCDPT_H_PULSE, LCDPT_H_BACK, LCDPT_H_DATA, LCDPT_H_FRONT} lcdpt_hstate_t;
  typedef enum {LCDPT_V_PULSE, LCDPT_V_BACK, LCDPT_V_DATA, LCDPT_V_FRONT} lcdpt_vstate_t;
  typedef enum {LCDPT_D_IDLE, LCDPT_D_BURST} lcdpt_dstate_t;
endpackage

// >>> verification/lcdpt_bus_model.sv
// System bus memory model that answers fetch bursts with words, sometimes stalling.
`timescale 1ns/1ps
module lcdpt_bus_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fetch bus
  input wire logic busReq,
  input wire logic [7:0] busBurstLen,
  output logic busWordValid,
  output logic [31:0] busWordData
);
  logic [7:0] beatsLeft;
  logic [7:0] left;
  logic reqSeen;
  logic [31:0] wordCount;
  // Each burst gets exactly the announced number of beats, never one more.
  always @(posedge ref_clk) begin
    reqSeen <= busReq;
    left = (busReq && !reqSeen) ? busBurstLen : beatsLeft;
    if (rst) begin
      beatsLeft <= 8'h00;
      busWordValid <= 1'b0;
      busWordData <= 32'h00000000;
      wordCount <= 32'h00000000;
    end else if (busReq && left != 8'h00 && $urandom_range(0, 2) != 0) begin
      busWordValid <= 1'b1;
      busWordData <= wordCount;
      wordCount <= wordCount + 32'h00000001;
      beatsLeft <= left - 8'h01;
    end else begin
      // Idle data lines keep changing so a stale word is never mistaken for a good one.
      busWordValid <= 1'b0;
      busWordData <= ~busWordData;
      beatsLeft <= left;
    end
  end
endmodule // lcdpt_bus_model

// >>> verification/lcdpt_core_test.sv
// Self-checking bench for the panel timing core.
`timescale 1ns/1ps
`include "lcdpt_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module lcdpt_core_test;
  import lcdpt_pkg::*;
  logic ref_clk, rst, regWr, regRd, rdLate, busReq, busWordValid;
  logic pixelClockPin, verticalSyncPin, horizontalSyncPin, dataEnablePin;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, busWordData, rnd;
  logic [7:0] busBurstLen;
  logic [23:0] panelDataPins;
  logic [63:0] expQ[$];
  logic [3:0] pins;
  logic [11:0] ofs[7] = '{12'h018, 12'h01C, 12'h800, 12'h804, 12'h808, 12'h80C, 12'h810};
  logic [31:0] rv[7] = '{`LCDPT_RST_DMA_CFG, `LCDPT_RST_DMA_CTRL, `LCDPT_RST_CTRL1,
    `LCDPT_RST_CTRL2, `LCDPT_RST_VTIM, `LCDPT_RST_HTIM, `LCDPT_RST_SIZE};
  logic [31:0] mk[7] = '{32'h7F7FFFFF, 32'h00000007, 32'h001FF001, 32'hC0009FFF,
    32'h0F3FFFFF, 32'hFFE03FFF, 32'hFFE007FF};
  int fail_count, checks_done, hi, per, k;
  assign pins = {pixelClockPin, verticalSyncPin, dataEnablePin, horizontalSyncPin};
  lcdpt_core lcdpt_core_inst (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .busReq(busReq), .busBurstLen(busBurstLen), .busWordValid(busWordValid),
    .busWordData(busWordData), .pixelClockPin(pixelClockPin),
    .verticalSyncPin(verticalSyncPin), .horizontalSyncPin(horizontalSyncPin),
    .dataEnablePin(dataEnablePin), .panelDataPins(panelDataPins));
  lcdpt_bus_model lcdpt_bus_model_inst (.ref_clk(ref_clk), .rst(rst), .busReq(busReq),
    .busBurstLen(busBurstLen), .busWordValid(busWordValid), .busWordData(busWordData));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Read data stands only in the cycle after the strobe, so it is compared there.
  always @(posedge ref_clk) rdLate <= regRd;
  always @(negedge ref_clk) begin : watch
    logic [63:0] e;
    if (rdLate === 1'b1) begin
      e = expQ.pop_front();
      `CHK(regRdData & e[31:0], e[63:32])
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    expQ.push_back({e, m});
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask
  // Measures one whole high pulse of a pin and the period up to its next rise.
  task automatic pulse(input int i);
    hi = 0;
    per = 0;
    k = 0;
    while (pins[i] !== 1'b0 && k < 5000) begin @(negedge ref_clk); k++; end
    while (pins[i] !== 1'b1 && k < 5000) begin @(negedge ref_clk); k++; end
    while (pins[i] === 1'b1 && k < 5000) begin @(negedge ref_clk); hi++; k++; end
    while (pins[i] !== 1'b1 && k < 5000) begin @(negedge ref_clk); per++; k++; end
    per = per + hi;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    final_report;
  end
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'h000;
    regWrData = 32'h00000000;
    rnd = $urandom(32'h95eddac8);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ofs[i], rv[i], 32'hFFFFFFFF);
    $display("reset values done");
    for (int i = 0; i < 7; i++) begin
      rnd = $urandom() & ((i == 1) ? 32'hFFFFFFFE : 32'hFFFFFFFF);
      wr(ofs[i], rnd);
      rd(ofs[i], (i == 1) ? 32'h00000000 : (rnd & mk[i]), mk[i]);
    end
    wr(12'h814, $urandom());
    rd(12'h814, 32'h00000000, 32'hFFFFFFFF);
    $display("register access done");
    wr(12'h800, 32'h00000000);
    wr(12'h804, 32'h00000082);
    wr(12'h808, 32'h00010101);
    wr(12'h80C, 32'h00800302);
    wr(12'h810, 32'h00A00003);
    wr(12'h018, 32'h03000010);
    wr(12'h01C, 32'h00000001);
    k = 0;
    while (busReq !== 1'b1 && k < 5000) begin @(negedge ref_clk); k++; end
    `CHK(busBurstLen, 8'h04)
    rd(12'h01C, 32'h00000005, 32'h00000007);
    pulse(0);
    `CHK(hi, 8)
    `CHK(per, 36)
    pulse(1);
    `CHK(hi, 12)
    pulse(2);
    `CHK(hi, 72)
    `CHK(per, 288)
    while (verticalSyncPin !== 1'b0) @(negedge ref_clk);
    while (verticalSyncPin !== 1'b1) @(negedge ref_clk);
    k = 0;
    while (horizontalSyncPin !== 1'b1 && k < 500) begin @(negedge ref_clk); k++; end
    `CHK(k, 2)
    $display("timing done");
    wr(12'h804, 32'h00000482);
    pulse(0);
    `CHK(hi, 28)
    wr(12'h804, 32'h00008082);
    wr(12'h800, 32'h00000001);
    pulse(0);
    `CHK(hi, 4)
    wr(12'h800, 32'h00002000);
    pulse(3);
    `CHK(hi, 3)
    `CHK(per, 6)
    $display("pixel clock done");
    wr(12'h808, 32'h00000000);
    wr(12'h804, 32'h00000080);
    pulse(2);
    `CHK(hi, 108)
    `CHK(per, 540)
    `CHK(panelDataPins & 24'hFFFFF0, 24'h000000)
    $display("passive mode done");
    final_report;
  end
endmodule // lcdpt_core_test
